//--- rtl/psl_dev.sv
// Device end: link timers, capture, compare and the software-driven pin line.
//
// Function
// (RL1) Link runs at 1200 bps, three percent tolerance.
// (RL2) Frame is 19 bit periods, each starts falling.
// (RL3) Sync bit is low 1/16 to 3/16.
// (RL4) Zero bit is low 5/16 to 8/16.
// (RL5) One bit is low 10/16 to 14/16.
// (RL6) Pause, direction, addresses, parity, data, parity, acknowledge.
// (RL7) Pause is three syncs; direction zero from master.
// (RL8) Register address bit 3 selects write.
// (RL9) First parity is odd parity of eight bits; the master sends their plain XOR, which is even parity.
// (RL10) Second parity is parity of data word.
// (RL11) Slave always sends acknowledge, zero on success.
// (RL12) Slave sends data, parity and acknowledge on read.
// (RL13) Slave drives low inside sync time, releases later.
// (RL14) Link mode only while control bit 6 set.
// (RL15) Low-width timer runs 131 kHz, falling to rising.
// (RL16) Sync timer counts continuously at 5 MHz.
// (RL17) Falling edge copies sync timer into capture.
// (RL18) Timer equal compare with bit 5 sets flag.
// (RL19) Software times transmitted pulses through compare.
// (RL20) Software-driven output line reaches the bus pin.
// (RL21) Software handles bit 8 when changing direction.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module psl_dev
   import psl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   psl_if.dev link
);
   localparam logic [1:0] FAST_LAST = 2'(FAST_DIV - 1);
   localparam logic [7:0] SLOW_LAST = 8'(SLOW_DIV - 1);

   typedef struct packed {
      logic [15:0] sync_tmr;
      logic [15:0] low_tmr;
      logic [15:0] capture;
      logic [15:0] compare;
      logic [8:0] control;
      logic cmp_flag;
      logic rise_flag;
      logic low_run;
      logic out_level;
      logic line_q;
      logic [1:0] fast_cnt;
      logic [7:0] slow_cnt;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic irq;
      logic drive;
   } psl_dev_st_t;

   psl_dev_st_t st;
   psl_dev_st_t next_st;
   logic mode;
   logic fall;
   logic rise;
   logic fast_tick;
   logic slow_tick;
   logic access;
   logic [15:0] sync_inc;

   // Edge and tick decode from the current state.
   always_comb begin
      mode = st.control[CTL_MODE_BIT]; // RL14
      fall = st.line_q && !link.line; // RL2
      rise = !st.line_q && link.line;
      fast_tick = (st.fast_cnt == FAST_LAST);
      slow_tick = (st.slow_cnt == SLOW_LAST);
      access = psel && penable;
      sync_inc = st.sync_tmr + 16'h0001;
   end

   // Next-state logic: bus access first, then hardware events, so a set
   // landing in the same cycle as a software clear wins.
   always_comb begin
      next_st = st;
      next_st.line_q = link.line;
      next_st.ready = 1'b0;
      next_st.err = 1'b0;

      // Dividers that make the 5 MHz and 131 kHz enables.
      next_st.fast_cnt = fast_tick ? 2'h0 : st.fast_cnt + 2'h1;
      next_st.slow_cnt = slow_tick ? 8'h00 : st.slow_cnt + 8'h01;

      // Read: the answer is latched on the same edge that raises pready.
      if (access && !st.ready) begin
         next_st.ready = 1'b1;
         next_st.rdata = 32'h00000000;
         if (paddr == ADDR_CONTROL) begin
            next_st.rdata = {23'h000000, st.control};
         end else if (paddr == ADDR_STATUS) begin
            next_st.rdata[STA_CMP_BIT] = st.cmp_flag;
            next_st.rdata[STA_RISE_BIT] = st.rise_flag;
         end else if (paddr == ADDR_SYNC_TIMER) begin
            next_st.rdata = {16'h0000, st.sync_tmr};
         end else if (paddr == ADDR_LOW_TIMER) begin
            next_st.rdata = {16'h0000, st.low_tmr};
         end else if (paddr == ADDR_PORT2) begin
            next_st.rdata[P2_OUT_BIT] = st.out_level;
            next_st.rdata[P2_PIN_BIT] = link.line;
         end else if (paddr == ADDR_CAPTURE) begin
            next_st.rdata = {16'h0000, st.capture};
         end else if (paddr == ADDR_COMPARE) begin
            next_st.rdata = {16'h0000, st.compare};
         end else begin
            next_st.err = 1'b1;
         end
      end

      // Write: takes effect on the edge where pready is seen high.
      if (access && st.ready && pwrite) begin
         if (paddr == ADDR_CONTROL) begin
            next_st.control = pwdata[8:0];
         end else if (paddr == ADDR_STATUS) begin
            // Write one to clear.
            if (pwdata[STA_CMP_BIT]) begin
               next_st.cmp_flag = 1'b0;
            end
            if (pwdata[STA_RISE_BIT]) begin
               next_st.rise_flag = 1'b0;
            end
         end else if (paddr == ADDR_PORT2) begin
            next_st.out_level = pwdata[P2_OUT_BIT]; // RL20
         end else if (paddr == ADDR_COMPARE) begin
            next_st.compare = pwdata[15:0]; // RL19
         end
      end

      if (mode) begin
         // Free-running timer; bus edges never stop or clear it.
         if (fast_tick) begin
            next_st.sync_tmr = sync_inc; // RL16
         end
         // The compare flag is set on the tick that reaches the compare
         // value, so clearing it while the timer still matches does not
         // make it set again at once.
         if (fast_tick && st.control[CTL_CMP_EN_BIT] && sync_inc == st.compare) begin
            next_st.cmp_flag = 1'b1; // RL18
         end
         if (fall) begin
            next_st.capture = st.sync_tmr; // RL17
            next_st.low_tmr = 16'h0000; // RL15
            next_st.low_run = 1'b1; // RL15
         end else if (rise && st.low_run) begin
            next_st.low_run = 1'b0; // RL15
            if (st.control[CTL_RISE_EN_BIT]) begin
               next_st.rise_flag = 1'b1; // RL15
            end
         end else if (st.low_run && slow_tick) begin
            next_st.low_tmr = st.low_tmr + 16'h0001; // RL15
         end
      end else begin
         // Outside link mode the low-width timer is parked; a pulse in
         // progress is abandoned rather than measured wrongly.
         next_st.low_run = 1'b0;
      end

      // Interrupt line follows the enabled sticky flags.
      next_st.irq = (next_st.cmp_flag && next_st.control[CTL_CMP_EN_BIT])
                    || (next_st.rise_flag && next_st.control[CTL_RISE_EN_BIT]);

      // Open drain: only a low level is driven; high means released.
      next_st.drive = !next_st.out_level; // RL13 RL11
   end

   // State register.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
         st.control <= CONTROL_RST;
         st.capture <= CAPTURE_RST;
         st.compare <= COMPARE_RST;
         st.out_level <= 1'b1;
         st.line_q <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register; the link data pin is tied low.
   assign prdata = st.rdata;
   assign pready = st.ready;
   assign pslverr = st.err;
   assign irq = st.irq;
   assign link.dev_o = 1'b0;
   assign link.dev_oe = st.drive; // RL20
endmodule
`default_nettype wire

//--- rtl/psl_if.sv
// Open-drain link wire shared by the master node and the device.
`timescale 1ns/1ps
`default_nettype none
interface psl_if;
   logic mst_o;
   logic mst_oe;
   logic dev_o;
   logic dev_oe;
   logic line;

   // The wire is low whenever either end drives a low, high otherwise.
   assign line = !((mst_oe && !mst_o) || (dev_oe && !dev_o));

   modport mst (output mst_o, output mst_oe, input line);
   modport dev (output dev_o, output dev_oe, input line);
endinterface
`default_nettype wire

//--- rtl/psl_mst.sv
// Master node: sends one frame per request and reads back slave bits.
`timescale 1ns/1ps
`default_nettype none
module psl_mst
   import psl_pkg::*;
#(
   parameter int SUB_CYC = SIXTEENTH_CYC
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic start,
   input wire logic [2:0] slave_addr,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] wdata,
   output logic busy,
   output logic done,
   output logic [7:0] rdata,
   output logic ack_bit,
   output logic parity_err,
   psl_if.mst link
);
   // One sixteenth of a bit period; a shorter slot speeds the link up in proportion.
   localparam logic [10:0] DIV_LAST = 11'(SUB_CYC - 1);
   localparam logic [3:0] SUB_LAST = 4'(SUBS_PER_BIT - 1);
   localparam logic [4:0] LAST_IDX = 5'(IDX_ACK);

   typedef enum {PSL_IDLE, PSL_RUN} psl_mst_state_t;

   typedef struct packed {
      psl_mst_state_t state;
      logic [10:0] div_cnt;
      logic [3:0] sub;
      logic [4:0] idx;
      logic [21:0] frame;
      logic is_read;
      logic [9:0] rx;
      logic drive;
      logic busy;
      logic done;
      logic [7:0] rdata;
      logic ack_bit;
      logic parity_err;
   } psl_mst_st_t;

   psl_mst_st_t st;
   psl_mst_st_t next_st;
   logic tick;
   logic p1;

   // Low time in sixteenths for a bit, given its index and value.
   function automatic logic [4:0] low_len(input logic [4:0] idx, input logic rd,
                                          input logic val);
      logic slave_bit;
      slave_bit = (idx == LAST_IDX) || (rd && idx >= 5'(IDX_DATA)); // RL12 RL11
      if (idx < 5'(PAUSE_BITS)) begin
         low_len = 5'(SYNC_TYP16); // RL3 RL7
      end else if (slave_bit) begin
         low_len = 5'(KICK16); // RL13
      end else if (val) begin
         low_len = 5'(ONE_TYP16); // RL5
      end else begin
         low_len = 5'(ZERO_TYP16); // RL4
      end
   endfunction

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      tick = (st.div_cnt == DIV_LAST); // RL1
      p1 = ^{1'b0, slave_addr, reg_addr}; // RL9
      case (st.state)
         PSL_IDLE: begin
            if (start) begin
               // Pause, direction, addresses, parity, data, parity, ack.
               next_st.frame = {3'b000, 1'b0, slave_addr, reg_addr, p1,
                                wdata, ^wdata, 1'b1}; // RL6 RL7 RL10
               next_st.is_read = !reg_addr[REG_WRITE_BIT]; // RL8
               next_st.state = PSL_RUN;
               next_st.idx = 5'h00;
               next_st.sub = 4'h0;
               next_st.div_cnt = 11'h000;
               next_st.rx = 10'h000;
               next_st.busy = 1'b1;
               next_st.drive = 1'b1; // RL2
            end
         end
         PSL_RUN: begin
            next_st.div_cnt = tick ? 11'h000 : st.div_cnt + 11'h001;
            if (tick) begin
               // Slave bits are read between the zero and one windows.
               if (st.sub == 4'(SAMPLE16)
                   && low_len(st.idx, st.is_read, st.frame[21]) == 5'(KICK16)
                   && st.idx >= 5'(PAUSE_BITS)) begin
                  next_st.rx = {st.rx[8:0], !link.line}; // RL13
               end
               if (st.sub == SUB_LAST) begin
                  if (st.idx == LAST_IDX) begin
                     next_st.state = PSL_IDLE;
                     next_st.busy = 1'b0;
                     next_st.done = 1'b1;
                     next_st.drive = 1'b0;
                     next_st.ack_bit = st.rx[0]; // RL11
                     if (st.is_read) begin
                        next_st.rdata = st.rx[9:2];
                        next_st.parity_err = ^st.rx[9:1]; // RL10
                     end else begin
                        next_st.parity_err = 1'b0;
                     end
                  end else begin
                     // Every period opens with a falling edge.
                     next_st.idx = st.idx + 5'h01;
                     next_st.sub = 4'h0;
                     next_st.frame = {st.frame[20:0], 1'b0};
                     next_st.drive = 1'b1; // RL2
                  end
               end else begin
                  next_st.sub = st.sub + 4'h1;
                  next_st.drive = ({1'b0, st.sub} + 5'h01)
                                  < low_len(st.idx, st.is_read, st.frame[21]);
               end
            end
         end
         default: begin
            next_st.state = PSL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
         st.state <= PSL_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign busy = st.busy;
   assign done = st.done;
   assign rdata = st.rdata;
   assign ack_bit = st.ack_bit;
   assign parity_err = st.parity_err;
   assign link.mst_o = 1'b0;
   assign link.mst_oe = st.drive;
endmodule
`default_nettype wire

//--- rtl/psl_pkg.sv
// Shared constants for the pulse-width-modulated single-wire serial link.
package psl_pkg;
   // Clock and link rates.
   localparam int CLK_HZ = 20_000_000;
   localparam int BIT_RATE_BPS = 1200; // RL1
   localparam int BIT_RATE_MIN_BPS = 1164; // RL1
   localparam int BIT_RATE_MAX_BPS = 1236; // RL1
   localparam int FAST_HZ = 5_000_000;
   localparam int SLOW_HZ = 131_000;
   // Cycles of clk_sys per sixteenth of a bit period, rounded down.
   localparam int SIXTEENTH_CYC = CLK_HZ / (BIT_RATE_BPS * 16);
   localparam int FAST_DIV = CLK_HZ / FAST_HZ;
   localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
   localparam int SUBS_PER_BIT = 16;

   // Low times in sixteenths of the bit period.
   localparam int SYNC_MIN16 = 1; // RL3
   localparam int SYNC_TYP16 = 2; // RL3
   localparam int SYNC_MAX16 = 3; // RL3
   localparam int ZERO_MIN16 = 5; // RL4
   localparam int ZERO_TYP16 = 6; // RL4
   localparam int ZERO_MAX16 = 8; // RL4
   localparam int ONE_MIN16 = 10; // RL5
   localparam int ONE_TYP16 = 12; // RL5
   localparam int ONE_MAX16 = 14; // RL5
   localparam int KICK16 = 1;
   localparam int SAMPLE16 = 9;

   // Frame layout by bit index, pause first.
   localparam int PAUSE_BITS = 3;
   localparam int FRAME_BITS = 19;
   localparam int TOTAL_BITS = PAUSE_BITS + FRAME_BITS;
   localparam int IDX_DATA = 12;
   localparam int IDX_ACK = 21;
   localparam int REG_WRITE_BIT = 3;

   // Register map, byte addresses.
   localparam logic [31:0] ADDR_CONTROL = 32'hffff0780;
   localparam logic [31:0] ADDR_STATUS = 32'hffff0784;
   localparam logic [31:0] ADDR_SYNC_TIMER = 32'hffff0788;
   localparam logic [31:0] ADDR_LOW_TIMER = 32'hffff078c;
   localparam logic [31:0] ADDR_PORT2 = 32'hffff0790;
   localparam logic [31:0] ADDR_CAPTURE = 32'hffff0794;
   localparam logic [31:0] ADDR_COMPARE = 32'hffff0798;

   // Field positions.
   localparam int CTL_CMP_EN_BIT = 5;
   localparam int CTL_MODE_BIT = 6;
   localparam int CTL_RISE_EN_BIT = 8;
   localparam int STA_RISE_BIT = 1;
   localparam int STA_CMP_BIT = 3;
   localparam int P2_OUT_BIT = 0;
   localparam int P2_PIN_BIT = 1;

   // Reset values.
   localparam logic [15:0] CAPTURE_RST = 16'h0000;
   localparam logic [15:0] COMPARE_RST = 16'h0000;
   localparam logic [8:0] CONTROL_RST = 9'h000;
endpackage

//--- testbench/psl_props.sv
// Checker for the open-drain link wire between master node and device.
`timescale 1ns/1ps
`default_nettype none
module psl_props
   import psl_pkg::*;
#(
   parameter int SUB_CYC = SIXTEENTH_CYC
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic mst_o,
   input wire logic mst_oe,
   input wire logic dev_o,
   input wire logic dev_oe,
   input wire logic line
);
   // Bounds in clk_sys cycles, widened over the whole rate tolerance.
   // The slot is taken as the nominal rate; lower bounds round down, upper ones up.
   localparam int NOM = SUB_CYC * BIT_RATE_BPS;
   localparam int RND = BIT_RATE_MIN_BPS - 1;
   localparam int SYN_LO = NOM * SYNC_MIN16 / BIT_RATE_MAX_BPS;
   localparam int SYN_HI = (NOM * SYNC_MAX16 + RND) / BIT_RATE_MIN_BPS;
   localparam int ZER_LO = NOM * ZERO_MIN16 / BIT_RATE_MAX_BPS;
   localparam int ZER_HI = (NOM * ZERO_MAX16 + RND) / BIT_RATE_MIN_BPS;
   localparam int ONE_LO = NOM * ONE_MIN16 / BIT_RATE_MAX_BPS;
   localparam int ONE_HI = (NOM * ONE_MAX16 + RND) / BIT_RATE_MIN_BPS;
   localparam int PER_LO = NOM * SUBS_PER_BIT / BIT_RATE_MAX_BPS;
   localparam int PER_HI = (NOM * SUBS_PER_BIT + RND) / BIT_RATE_MIN_BPS;
   // Low times above this are ones; a quiet gap this long closes a frame.
   localparam int ONE_CUT = SUB_CYC * (ZERO_MAX16 + ONE_MIN16) / 2;
   localparam int GAP = SUB_CYC * SUBS_PER_BIT * 5 / 4;
   logic [15:0] low_cnt;
   logic [15:0] gap_cnt;
   logic [4:0] idx;
   logic [7:0] hist;

   // Pulse width, fall spacing, pulse index and bit history; the gap saturates.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         low_cnt <= 16'h0;
         gap_cnt <= 16'hffff;
         idx <= 5'h0;
         hist <= 8'h0;
      end else begin
         low_cnt <= mst_oe ? low_cnt + 16'h1 : 16'h0;
         gap_cnt <= $fell(line) ? 16'h0 : (gap_cnt == 16'hffff ? gap_cnt : gap_cnt + 16'h1);
         if ($fell(mst_oe)) begin
            idx <= idx + 5'h1;
            hist <= {hist[6:0], low_cnt > ONE_CUT};
         end else if (gap_cnt > GAP) begin
            idx <= 5'h0;
         end
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   // End of a master pulse with a given index.
   sequence s_bit(int n);
      $fell(mst_oe) && idx == n;
   endsequence

   AST_MST_OPEN: assert property (mst_o == 1'b0)
      else $error("master pin drives a high level");
   AST_DEV_OPEN: assert property (dev_o == 1'b0)
      else $error("device pin drives a high level");
   AST_WIDTH: assert property ($fell(mst_oe) |->
      (low_cnt >= SYN_LO && low_cnt <= SYN_HI) || (low_cnt >= ZER_LO && low_cnt <= ZER_HI)
      || (low_cnt >= ONE_LO && low_cnt <= ONE_HI))
      else $error("master low time fits no bit type");
   AST_PERIOD: assert property ($fell(line) && idx != 5'h0 |->
      gap_cnt >= PER_LO - 1 && gap_cnt <= PER_HI)
      else $error("bit period out of range");
   AST_PAUSE: assert property ($fell(mst_oe) && idx < 5'h3 |-> low_cnt <= SYN_HI)
      else $error("pause pulse is not a sync");
   AST_DIR: assert property (s_bit(3) |-> low_cnt >= ZER_LO && low_cnt <= ZER_HI)
      else $error("direction bit is not zero");
   AST_HDR_PARITY: assert property (s_bit(11) |-> (low_cnt > ONE_CUT) == ^hist)
      else $error("header parity wrong");
   AST_DATA_PARITY: assert property (s_bit(20) |-> (low_cnt > ONE_CUT) == ^hist)
      else $error("data parity wrong");
   AST_ACK_SLAVE: assert property (s_bit(21) |-> low_cnt <= SYN_HI)
      else $error("master holds the acknowledge slot");
   AST_FRAME_LEN: assert property (gap_cnt == GAP |-> idx == 5'h0 || idx == 5'h16)
      else $error("frame pulse count wrong");
   AST_RESET: assert property ($fell(srst) |-> !mst_oe && !dev_oe)
      else $error("wire not released after reset");
endmodule
`default_nettype wire

//--- testbench/pwm_serial_link_assist_test.sv
// Testbench: device registers over APB and one master write frame.
`timescale 1ns/1ps
`default_nettype none
module pwm_serial_link_assist_test
   import psl_pkg::*;
;
   typedef struct packed {
      logic [31:0] a;
      logic w;
      logic [31:0] d;
      logic [31:0] e;
      logic er;
   } psl_row_t;
   // Address, write, data, expected read data, expected error.
   localparam psl_row_t ROWS [0:10] = '{
      '{ADDR_CAPTURE, 1'b0, 32'h0, 32'h0, 1'b0},
      '{ADDR_COMPARE, 1'b0, 32'h0, 32'h0, 1'b0},
      '{ADDR_CONTROL, 1'b0, 32'h0, 32'h0, 1'b0},
      '{ADDR_PORT2, 1'b0, 32'h0, 32'h3, 1'b0},
      '{ADDR_COMPARE, 1'b1, 32'h1234, 32'h0, 1'b0},
      '{ADDR_COMPARE, 1'b0, 32'h0, 32'h1234, 1'b0},
      '{ADDR_CAPTURE, 1'b1, 32'hffff, 32'h0, 1'b0},
      '{ADDR_CAPTURE, 1'b0, 32'h0, 32'h0, 1'b0},
      '{32'hffff07a0, 1'b0, 32'h0, 32'h0, 1'b1},
      '{ADDR_CONTROL, 1'b1, 32'h60, 32'h0, 1'b0},
      '{ADDR_CONTROL, 1'b0, 32'h0, 32'h60, 1'b0}};
   // Link slot in cycles, shorter than the real one so that a frame fits the run budget.
   localparam int SIXT = 200;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic start = 1'b0;
   logic [2:0] slave_addr = 3'h5;
   logic [3:0] reg_addr = 4'ha;
   logic [7:0] wdata = 8'h5a;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic busy;
   logic done;
   logic [7:0] rdata;
   logic ack_bit;
   logic parity_err;
   int err_count = 0;
   int checks_done = 0;
   int lw = 0;
   int nb = 0;
   int n;
   logic [31:0] rd;
   logic [31:0] c;
   logic er;
   logic [18:0] fb;
   logic [1:0] cls [0:21];

   psl_if lnk();
   psl_dev psl_dev_i (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .link(lnk.dev));
   psl_mst #(.SUB_CYC(SIXT)) psl_mst_i (.clk_sys(clk_sys), .srst(srst), .start(start),
      .slave_addr(slave_addr), .reg_addr(reg_addr), .wdata(wdata), .busy(busy), .done(done),
      .rdata(rdata), .ack_bit(ack_bit), .parity_err(parity_err), .link(lnk.mst));
   psl_props #(.SUB_CYC(SIXT)) psl_props_i (.clk_sys(clk_sys), .srst(srst),
      .mst_o(lnk.mst_o), .mst_oe(lnk.mst_oe), .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe),
      .line(lnk.line));

   // Clock at 20 MHz.
   initial forever #25 clk_sys = ~clk_sys;

   // Classify each low pulse on the wire; a start request clears the record.
   always @(posedge clk_sys) begin
      if (start) nb <= 0;
      else if (lnk.line === 1'b0) lw <= lw + 1;
      else if (lw > 0) begin
         if (nb < 22) cls[nb] <= lw < 4 * SIXT ? 2'h0 : (lw < 9 * SIXT ? 2'h1 : 2'h2);
         nb <= nb + 1;
         lw <= 0;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task results;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // One APB transfer, entered just after a rising edge; waits on pready.
   task apb(input logic [31:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // No wait count is assumed; only the watchdog ends a hung transfer.
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   // Watchdog sized for one frame of 22 bit periods plus register work.
   initial begin
      repeat (90000) @(posedge clk_sys);
      err_count++;
      results();
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 11; i++) begin
         apb(ROWS[i].a, ROWS[i].w, ROWS[i].d);
         chk({31'h0, er}, {31'h0, ROWS[i].er});
         if (!ROWS[i].w) chk(rd, ROWS[i].e);
      end
      // Device pulls the wire low by software, then times its release by compare.
      apb(ADDR_PORT2, 1'b1, 32'h0);
      apb(ADDR_PORT2, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(ADDR_CAPTURE, 1'b0, 32'h0);
      c = rd;
      apb(ADDR_SYNC_TIMER, 1'b0, 32'h0);
      chk({31'h0, rd != c && rd - c < 32'h40}, 32'h1);
      apb(ADDR_COMPARE, 1'b1, c + 32'hc8);
      chk({31'h0, irq}, 32'h0);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
      chk({31'h0, n > 600 && n < 820}, 32'h1);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      chk(rd & 32'h8, 32'h8);
      apb(ADDR_STATUS, 1'b1, 32'h8);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      chk(rd & 32'h8, 32'h0);
      chk({31'h0, irq}, 32'h0);
      apb(ADDR_PORT2, 1'b1, 32'h1);
      apb(ADDR_LOW_TIMER, 1'b0, 32'h0);
      c = rd;
      repeat (400) @(posedge clk_sys);
      apb(ADDR_LOW_TIMER, 1'b0, 32'h0);
      chk(rd, c);
      chk({31'h0, c > 32'h2 && c < 32'ha}, 32'h1);
      // Receiving: with the rise event enabled, a released pulse sets the flag and irq.
      apb(ADDR_CONTROL, 1'b1, 32'h140);
      apb(ADDR_PORT2, 1'b1, 32'h0);
      apb(ADDR_PORT2, 1'b1, 32'h1);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      chk(rd & 32'h2, 32'h2);
      chk({31'h0, irq}, 32'h1);
      apb(ADDR_STATUS, 1'b1, 32'h2);
      chk({31'h0, irq}, 32'h0);
      // Out of link mode the sync timer must hold.
      apb(ADDR_CONTROL, 1'b1, 32'h0);
      apb(ADDR_SYNC_TIMER, 1'b0, 32'h0);
      c = rd;
      apb(ADDR_SYNC_TIMER, 1'b0, 32'h0);
      chk(rd, c);
      // Master write frame; the device stays silent, so the ack reads zero.
      fb = {1'b0, 3'h5, 4'ha, ^{3'h5, 4'ha}, 8'h5a, ^8'h5a, 1'b0};
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      @(posedge clk_sys);
      chk({31'h0, busy}, 32'h1);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (done !== 1'b1 && n < 23 * 16 * SIXT);
      chk({31'h0, done}, 32'h1);
      chk({31'h0, busy}, 32'h0);
      chk({31'h0, ack_bit}, 32'h0);
      chk({31'h0, parity_err}, 32'h0);
      @(posedge clk_sys);
      chk(nb, 32'h16);
      for (int i = 0; i < 22; i++) begin
         chk({30'h0, cls[i]}, (i < 3 || i == 21) ? 32'h0 : (fb[21 - i] ? 32'h2 : 32'h1));
      end
      results();
   end
endmodule
`default_nettype wire
